// File: rtl/trip_auto_reset_sequencer.v
// automatic recovery sequencer after protective trips, with register port
// ===========================================================================
// Overview of operation
// - resettable trip triggers automatic reset, no alarm
// - retries exhausted: assert alarm, stop retrying
// - retry count zero disables auto reset
// - wait programmed interval from trip entry
// - only seven fault classes are retryable
// - output function code 26 drives retry status
// - motor select 1 picks horsepower table
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "trip_retry_map.vh"
module trip_auto_reset_sequencer #(
  parameter integer TICK_CYCLES = `TICK_NS / `CLK_NS  // cycles per ms tick
)(
  input  wire        mclk_i,          // 125 MHz system clock
  input  wire        arst_n_i,        // async reset, active low
  input  wire [3:0]  addr_i,          // register index
  input  wire [31:0] wdata_i,         // write data
  input  wire        wr_i,            // write strobe
  input  wire        rd_i,            // read strobe
  output reg  [31:0] rdata_o,         // read data, cycle after rd_i
  input  wire [7:0]  fault_i,         // protective trip causes, level
  input  wire        run_ok_i,        // drive running normally
  output reg         trip_reset_o,    // internal reset command pulse
  output reg         fault_alarm_out_o, // alarm output
  output reg         transistor_output_terminal_o,
  output reg         relay_output_terminal_o,
  output reg         hp_table_m1_o,   // motor 1 uses horsepower table
  output reg         hp_table_m2_o,   // motor 2 uses horsepower table
  output reg  [3:0]  table_index_o,   // capacity index into table set
  output reg         irq_o            // level interrupt
);
  // ===========================================================================
  // states, one-hot
  localparam [3:0] S_IDLE  = 4'b0001;  // normal operation
  localparam [3:0] S_WAIT  = 4'b0010;  // tripped, counting interval
  localparam [3:0] S_CHECK = 4'b0100;  // reset issued, watching result
  localparam [3:0] S_ALARM = 4'b1000;  // locked out with alarm

  // ===========================================================================
  // fault input synchroniser: three stages, accept when 2nd and 3rd agree
  reg [7:0] flt_s1_q;                 // first stage, only read by second
  reg [7:0] flt_s2_q;                 // second stage
  reg [7:0] flt_s3_q;                 // third stage
  reg [7:0] flt_q;                    // accepted fault vector
  reg       run_s1_q;                 // run flag stages
  reg       run_s2_q;
  reg       run_s3_q;
  reg       run_q;                    // accepted run flag
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flt_s1_q <= 8'h00;
      flt_s2_q <= 8'h00;
      flt_s3_q <= 8'h00;
      flt_q    <= 8'h00;
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
      run_s3_q <= 1'b0;
      run_q    <= 1'b0;
    end
    else
    begin
      flt_s1_q <= fault_i;
      flt_s2_q <= flt_s1_q;
      flt_s3_q <= flt_s2_q;
      // per bit: take the new level only once two stages agree
      flt_q    <= (flt_s2_q & flt_s3_q) | (flt_q & (flt_s2_q | flt_s3_q));
      run_s1_q <= run_ok_i;
      run_s2_q <= run_s1_q;
      run_s3_q <= run_s2_q;
      if (run_s2_q == run_s3_q)
        run_q <= run_s3_q;
    end
  end

  // ===========================================================================
  // helper functions
  // true when a tripped set holds only retryable causes
  function retryable;
    input [7:0] f;
    begin
      retryable = (f != 8'h00) && ((f & ~`FLT_RETRY_MASK) == 8'h00);
    end
  endfunction
  // output terminal function select matches the retry status code
  function fsel_retry;
    input [7:0] sel;
    begin
      fsel_retry = (sel == `FSEL_RETRY);
    end
  endfunction

  // ===========================================================================
  // registers
  reg [31:0] ctrl_q;                  // count, y1 and relay selects
  reg [15:0] interval_q;              // retry interval in ms ticks
  reg [3:0]  events_q;                // sticky events, write one to clear
  reg [3:0]  mask_q;                  // interrupt enables
  reg [7:0]  motor_q;                 // [1:0] m1 sel, [3:2] m2 sel, [7:4] cap
  wire [3:0] retry_count_setting = ctrl_q[`CTRL_CNT_LSB +: `CTRL_CNT_W];
  wire [7:0] output_y1_function_select = ctrl_q[`CTRL_Y1_LSB +: `FSEL_W];
  wire [7:0] relay_output_function_select = ctrl_q[`CTRL_RLY_LSB +: `FSEL_W];
  wire [15:0] retry_interval_setting = interval_q;
  // motor word fields; the layout itself lives in the map header
  wire [`MOTOR_SEL_W-1:0] motor1_type_select =
    motor_q[`MOT_M1_LSB +: `MOTOR_SEL_W];
  wire [`MOTOR_SEL_W-1:0] motor2_type_select =
    motor_q[`MOT_M2_LSB +: `MOTOR_SEL_W];
  wire [`CAP_IDX_W-1:0]   cap_index =
    motor_q[`MOT_CAP_LSB +: `CAP_IDX_W];

  // ===========================================================================
  // sequencer state
  reg [3:0]  state_q;                 // one-hot state
  reg [3:0]  tries_q;                 // resets issued in this sequence
  reg [15:0] wait_q;                  // elapsed ticks in the wait state, held at zero elsewhere
  reg        retry_in_progress_out;   // retry status level
  wire       tick;                    // 1 ms tick
  wire       tripped = (flt_q != 8'h00);
  reg  [3:0] ev_set;                  // events raised this cycle

  // ===========================================================================
  // interval time base: one pulse per millisecond
  tick_divider #(.DIV(TICK_CYCLES)) u_tick (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .tick_o   (tick)
  );

  // ===========================================================================
  // retry state machine
  // attempts count per sequence; only a clean run clears the count
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q      <= S_IDLE;
      tries_q      <= 4'h0;
      wait_q       <= 16'h0;
      trip_reset_o <= 1'b0;
      retry_in_progress_out <= 1'b0;
      ev_set       <= 4'h0;
    end
    else
    begin
      trip_reset_o <= 1'b0;
      ev_set       <= 4'h0;
      case (state_q)
        S_IDLE:
        begin
          wait_q <= 16'h0;
          if (tripped)
          begin
            ev_set[`EV_TRIP] <= 1'b1;
            // zero count or a non-retryable cause goes straight to alarm
            if (retry_count_setting == 4'h0 || !retryable(flt_q))
            begin
              state_q <= S_ALARM;
              ev_set[`EV_ALARM] <= 1'b1;
            end
            else if (tries_q >= retry_count_setting)
            begin
              state_q <= S_ALARM;
              ev_set[`EV_ALARM] <= 1'b1;
              retry_in_progress_out <= 1'b0;
            end
            else
            begin
              state_q <= S_WAIT;
              retry_in_progress_out <= 1'b1;
            end
          end
          else if (retry_in_progress_out && run_q && tick)
          begin
            // fault free run: recovery counts as done
            // until then a new trip keeps adding to the same attempt count
            if (wait_q >= `RUN_OK_TICKS - 16'h1)
            begin
              tries_q <= 4'h0;
              retry_in_progress_out <= 1'b0;
              ev_set[`EV_RECOVER] <= 1'b1;
            end
          end
        end
        S_WAIT:
        begin
          // interval counted from entry into the tripped state
          // an interval of zero issues the reset on the first cycle
          if (tick)
            wait_q <= wait_q + 16'h1;
          if (wait_q >= retry_interval_setting)
          begin
            trip_reset_o <= 1'b1;
            tries_q      <= tries_q + 4'h1;
            ev_set[`EV_RETRY] <= 1'b1;
            wait_q       <= 16'h0;
            state_q      <= S_CHECK;
          end
        end
        S_CHECK:
        begin
          // let the synchronised fault level settle after the reset pulse;
          // the fault path lags the pin by four cycles, so a tick shorter
          // than about eight cycles would see a stale trip and retry again
          // even though the cause has already gone
          if (tick)
            state_q <= S_IDLE;
        end
        default:
        begin
          // alarm holds until reset; no further attempts
          state_q <= S_ALARM;
          retry_in_progress_out <= 1'b0;
        end
      endcase
    end
  end

  // ===========================================================================
  // register writes and sticky events
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_q     <= {28'h0, `RST_COUNT};
      interval_q <= `RST_INTERVAL;
      events_q   <= 4'h0;
      mask_q     <= 4'h0;
      motor_q    <= 8'h00;
    end
    else
    begin
      // writes to the status index or unmapped indices are ignored
      if (wr_i && addr_i == `REG_CTRL)
        ctrl_q <= wdata_i;
      else if (wr_i && addr_i == `REG_INTERVAL)
        interval_q <= wdata_i[15:0];
      else if (wr_i && addr_i == `REG_MASK)
        mask_q <= wdata_i[3:0];
      else if (wr_i && addr_i == `REG_MOTOR)
        motor_q <= wdata_i[7:0];
      // set wins over a simultaneous write-one clear
      if (wr_i && addr_i == `REG_EVENTS)
        events_q <= (events_q & ~wdata_i[3:0]) | ev_set;
      else
        events_q <= events_q | ev_set;
    end
  end

  // ===========================================================================
  // read port and registered outputs
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o           <= 32'h0;
      fault_alarm_out_o <= 1'b0;
      transistor_output_terminal_o <= 1'b0;
      relay_output_terminal_o      <= 1'b0;
      hp_table_m1_o     <= 1'b0;
      hp_table_m2_o     <= 1'b0;
      table_index_o     <= 4'h0;
      irq_o             <= 1'b0;
    end
    else
    begin
      // unmapped or idle reads return zero
      if (!rd_i)
        rdata_o <= 32'h0;
      else if (addr_i == `REG_CTRL)
        rdata_o <= ctrl_q;
      else if (addr_i == `REG_INTERVAL)
        rdata_o <= {16'h0, interval_q};
      else if (addr_i == `REG_STATUS)
        rdata_o <= {16'h0, flt_q, tries_q, state_q};
      else if (addr_i == `REG_EVENTS)
        rdata_o <= {28'h0, events_q};
      else if (addr_i == `REG_MASK)
        rdata_o <= {28'h0, mask_q};
      else if (addr_i == `REG_MOTOR)
        rdata_o <= {24'h0, motor_q};
      else
        rdata_o <= 32'h0;
      fault_alarm_out_o <= (state_q == S_ALARM);
      transistor_output_terminal_o <=
        fsel_retry(output_y1_function_select) & retry_in_progress_out;
      relay_output_terminal_o <=
        fsel_retry(relay_output_function_select) & retry_in_progress_out;
      // either motor may pick the horsepower set on its own
      hp_table_m1_o <= (motor1_type_select == `MOTOR_HP_SEL);
      hp_table_m2_o <= (motor2_type_select == `MOTOR_HP_SEL);
      table_index_o <= cap_index;
      // level interrupt: any unmasked sticky event
      irq_o         <= |(events_q & mask_q);
    end
  end
endmodule
`default_nettype wire

// File: rtl/trip_retry_map.vh
// register offsets, field layout and timing constants of the trip retry block
`ifndef TRIP_RETRY_MAP_VH
`define TRIP_RETRY_MAP_VH
// ===========================================================================
// register indices (byte address = index)
`define REG_CTRL        4'h0
`define REG_INTERVAL    4'h1
`define REG_STATUS      4'h2
`define REG_EVENTS      4'h3
`define REG_MASK        4'h4
`define REG_MOTOR       4'h5
// ===========================================================================
// control register fields
`define CTRL_CNT_LSB    0
`define CTRL_CNT_W      4
`define CTRL_Y1_LSB     8
`define CTRL_RLY_LSB    16
`define FSEL_W          8
// ===========================================================================
// codes and constants
`define FSEL_RETRY      8'h1a
`define MOTOR_HP_SEL    2'h1
`define MOTOR_SEL_W     2
`define CAP_IDX_W       4
// motor word field positions
`define MOT_M1_LSB      0
`define MOT_M2_LSB      2
`define MOT_CAP_LSB     4
// fault class bit positions on the fault input vector
`define FLT_OVERCURRENT 0
`define FLT_OVERVOLTAGE 1
`define FLT_HEATSINK    2
`define FLT_BRAKE_RES   3
`define FLT_MOTOR_HOT   4
`define FLT_MOTOR_OVL   5
`define FLT_DRIVE_OVL   6
`define FLT_W           8
`define FLT_RETRY_MASK  8'h7f
// event bits
`define EV_TRIP         0
`define EV_RETRY        1
`define EV_ALARM        2
`define EV_RECOVER      3
`define EV_W            4
// reset values
`define RST_COUNT       4'h0
`define RST_INTERVAL    16'h0001
// one interval tick is 1 ms; cycles per tick at 125 MHz
`define TICK_NS         1000000
`define CLK_NS          8
// recovery: run must stay fault free this long before the counter clears
`define RUN_OK_TICKS    16'h0001
`endif

// File: rtl/tick_divider.v
// millisecond tick generator for the retry interval timer
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter integer DIV = 125000   // cycles per tick
)(
  input  wire mclk_i,
  input  wire arst_n_i,
  output reg  tick_o
);
  // ===========================================================================
  // free running divider
  reg [31:0] cnt_q;                  // cycle counter
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b0;
    end
    else if (cnt_q == DIV - 1)
    begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/trip_auto_reset_sequencer_monitor.sv
// port checker for the trip retry sequencer
`timescale 1ns/1ps
`default_nettype none
`include "trip_retry_map.vh"
module trip_seq_checker #(
  parameter integer TICK_CYCLES = `TICK_NS / `CLK_NS
)(
  input wire logic        mclk_i,
  input wire logic        arst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic [7:0]  fault_i,
  input wire logic        trip_reset_o,
  input wire logic        fault_alarm_out_o,
  input wire logic        transistor_output_terminal_o,
  input wire logic        relay_output_terminal_o,
  input wire logic        hp_table_m1_o,
  input wire logic        hp_table_m2_o,
  input wire logic [3:0]  table_index_o
);
  // ==========================================================
  // shadow of written settings
  logic [31:0] ctrl_q; // control word
  logic [15:0] ival_q; // interval in ticks
  logic [7:0]  mot_q;  // motor word
  logic [1:0]  age_q;  // cycles since control write
  logic [15:0] flt_q;  // cycles a fault is present
  wire         cfg_ok  = age_q == 2'h3; // settings have landed
  wire         y1_sel  = ctrl_q[15:8] == `FSEL_RETRY;
  wire         rly_sel = ctrl_q[23:16] == `FSEL_RETRY;
  // counters saturate so long runs never wrap into false hits
  always @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      ctrl_q <= 32'h0;
      ival_q <= `RST_INTERVAL;
      mot_q  <= 8'h0;
      age_q  <= 2'h3;
      flt_q  <= 16'h0;
    end
    else
    begin
      if (wr_i && addr_i == `REG_CTRL)
        ctrl_q <= wdata_i;
      if (wr_i && addr_i == `REG_INTERVAL)
        ival_q <= wdata_i[15:0];
      if (wr_i && addr_i == `REG_MOTOR)
        mot_q <= wdata_i[7:0];
      age_q <= (wr_i && addr_i == `REG_CTRL) ? 2'h0 :
        age_q + {1'b0, !cfg_ok};
      flt_q <= (fault_i == 8'h0) ? 16'h0 :
        flt_q + {15'h0, flt_q != 16'hffff};
    end
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // sequencer checks
  alarm_held_a: assert property (
    fault_alarm_out_o |=> fault_alarm_out_o) else $error("alarm dropped");
  alarm_quiet_a: assert property (
    fault_alarm_out_o |-> !trip_reset_o) else $error("reset in alarm");
  pulse_one_a: assert property (
    trip_reset_o |=> !trip_reset_o) else $error("long reset pulse");
  wait_span_a: assert property (
    trip_reset_o |-> flt_q >= (ival_q - 16'h1) * TICK_CYCLES)
    else $error("reset before interval");
  zero_count_a: assert property (
    cfg_ok && ctrl_q[3:0] == 4'h0 |->
    !trip_reset_o && (flt_q != 16'd12 || fault_alarm_out_o))
    else $error("retry with zero count");
  no_retry_a: assert property (
    flt_q == 16'd12 && fault_i[7] |-> fault_alarm_out_o)
    else $error("other fault did not alarm");
  term_off_a: assert property (
    cfg_ok |-> (y1_sel || !transistor_output_terminal_o) &&
    (rly_sel || !relay_output_terminal_o)) else $error("terminal unselected");
  term_pair_a: assert property (
    cfg_ok && y1_sel && rly_sel |->
    transistor_output_terminal_o == relay_output_terminal_o)
    else $error("terminals disagree");
  motor_map_a: assert property (
    (wr_i && addr_i == `REG_MOTOR) ##1 !wr_i [*2] |->
    hp_table_m1_o == (mot_q[1:0] == `MOTOR_HP_SEL) &&
    hp_table_m2_o == (mot_q[3:2] == `MOTOR_HP_SEL) &&
    table_index_o == mot_q[7:4]) else $error("motor table wrong");
  cover property (trip_reset_o);
  cover property ($rose(fault_alarm_out_o));
  cover property ($rose(transistor_output_terminal_o));
endmodule
bind trip_auto_reset_sequencer trip_seq_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) chk (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .fault_i(fault_i),
  .trip_reset_o(trip_reset_o), .fault_alarm_out_o(fault_alarm_out_o),
  .transistor_output_terminal_o(transistor_output_terminal_o),
  .relay_output_terminal_o(relay_output_terminal_o),
  .hp_table_m1_o(hp_table_m1_o), .hp_table_m2_o(hp_table_m2_o),
  .table_index_o(table_index_o));
`default_nettype wire

// File: verif/term_watch.sv
// outside equipment: counts retry runs seen on the terminals
`timescale 1ns/1ps
`default_nettype none
module term_watch (
  input  wire logic mclk_i,
  input  wire logic y1_i,
  input  wire logic rly_i,
  output var  int   y1_rise_o,
  output var  int   rly_rise_o
);
  logic y1_q  = 1'b0; // previous levels
  logic rly_q = 1'b0;
  int   y1_n  = 0;    // rising levels seen so far
  int   rly_n = 0;
  assign y1_rise_o  = y1_n;
  assign rly_rise_o = rly_n;
  // a new retry run shows as a rising level
  always @(posedge mclk_i)
  begin
    y1_n  <= y1_n + int'(y1_i === 1'b1 && y1_q !== 1'b1);
    rly_n <= rly_n + int'(rly_i === 1'b1 && rly_q !== 1'b1);
    y1_q  <= y1_i;
    rly_q <= rly_i;
  end
endmodule
`default_nettype wire

// File: verif/tb_trip_auto_reset_sequencer.sv
// self-checking bench for the trip retry sequencer
`timescale 1ns/1ps
`default_nettype none
`include "trip_retry_map.vh"
module tb_trip_auto_reset_sequencer;
  localparam int TK = 8; // short tick, still longer than the fault path lag
  logic        mclk_i, arst_n_i, wr_i, rd_i, run_ok_i, rst_p, fault_alarm_out;
  logic        y1, rly, m1, m2, irq;
  logic [3:0]  addr_i, idx;
  logic [7:0]  fault_i, f;
  logic [31:0] wdata_i, rdata_o, d;
  logic [31:0] rv[$] = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
  int          n_mismatch = 0, check_count = 0, seed = 20, np, c, y0, yr, rr;
  trip_auto_reset_sequencer #(.TICK_CYCLES(TK))
    trip_auto_reset_sequencer_inst (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fault_i(fault_i),
    .run_ok_i(run_ok_i), .trip_reset_o(rst_p), .fault_alarm_out_o(fault_alarm_out),
    .transistor_output_terminal_o(y1), .relay_output_terminal_o(rly),
    .hp_table_m1_o(m1), .hp_table_m2_o(m2), .table_index_o(idx), .irq_o(irq));
  term_watch term_watch_inst (.mclk_i(mclk_i), .y1_i(y1), .rly_i(rly),
    .y1_rise_o(yr), .rly_rise_o(rr));
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // compares, bus cycles and bounded waits
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch t=%0t word %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // wait for a level, counting reset pulses; a hang ends the run
  task automatic wait_sig(ref logic s, input logic v, output int n, p);
    p = 0;
    for (n = 1; n <= 400; n++)
    begin
      @(posedge mclk_i);
      #1 p += int'(rst_p === 1'b1);
      if (s === v)
        return;
    end
    n_mismatch++;
    $display("mismatch t=%0t wait ran out", $time);
    conclude();
  endtask
  task automatic do_reset();
    arst_n_i <= 1'b0;
    fault_i  <= 8'h0;
    run_ok_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
  endtask
  // model: pulses seen before the alarm for a held fault
  function automatic int exp_np(logic [7:0] fb, int cnt);
    return (fb[7] || cnt == 0) ? 0 : cnt;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial
  begin
    {arst_n_i, wr_i, rd_i, run_ok_i, addr_i, wdata_i, fault_i} = '0;
    do_reset();
    foreach (rv[i])
    begin
      rd((i < 6) ? 4'(i) : 4'hf, d);
      chk_reg(d, rv[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      d = {24'h0, 4'($random(seed)), 2'(3 - i), 2'(i)};
      wr(`REG_MOTOR, d);
      repeat (2) @(posedge mclk_i);
      #1 chk_pin(m1, i == 1);
      chk_pin(m2, i == 2);
      chk_reg({28'h0, idx}, {28'h0, d[7:4]});
    end
    // one retry then recovery; relay left unselected
    wr(`REG_CTRL, 32'h00051a02);
    wr(`REG_INTERVAL, 32'h3);
    wr(`REG_MASK, 32'h1);
    y0 = yr;
    f = 8'h1 << ({$random(seed)} % 7);
    @(posedge mclk_i) fault_i <= f;
    wait_sig(rst_p, 1'b1, c, np);
    chk_pin(c >= 2 * TK, 1'b1);
    chk_pin(c <= 3 * TK + 8, 1'b1);
    chk_pin(fault_alarm_out, 1'b0);
    chk_pin(y1, 1'b1);
    chk_pin(rly, 1'b0);
    chk_pin(irq, 1'b1);
    @(posedge mclk_i) fault_i <= 8'h0;
    run_ok_i <= 1'b1;
    wait_sig(y1, 1'b0, c, np);
    rd(`REG_STATUS, d);
    chk_reg(d, 32'h1);
    chk_reg(32'(yr - y0), 32'h1);
    rd(`REG_EVENTS, d);
    chk_reg(d, 32'hb);
    wr(`REG_EVENTS, 32'hf);
    rd(`REG_EVENTS, d);
    chk_reg(d, 32'h0);
    chk_pin(irq, 1'b0);
    // retries run out, both terminals selected
    run_ok_i <= 1'b0;
    wr(`REG_CTRL, 32'h001a1a02);
    @(posedge mclk_i) fault_i <= f;
    wait_sig(fault_alarm_out, 1'b1, c, np);
    chk_reg(32'(np), 32'(exp_np(f, 2)));
    rd(`REG_STATUS, d);
    chk_reg(d, {16'h0, f, 8'h28});
    chk_reg(32'(rr), 32'h1);
    @(posedge mclk_i) fault_i <= 8'h0;
    np = 0;
    repeat (40)
    begin
      @(posedge mclk_i);
      #1 np += int'(rst_p === 1'b1);
    end
    chk_reg(32'(np), 32'h0);
    chk_pin(fault_alarm_out, 1'b1);
    // zero count alarms at once; masked event keeps irq low
    do_reset();
    fault_i <= f;
    wait_sig(fault_alarm_out, 1'b1, c, np);
    chk_reg(32'(np), 32'(exp_np(f, 0)));
    chk_pin(irq, 1'b0);
    // every class with one retry; bit 7 never retries
    for (int k = 0; k < 8; k++)
    begin
      do_reset();
      wr(`REG_CTRL, 32'h1);
      f = (k == 7) ? 8'h81 : 8'h1 << k;
      @(posedge mclk_i) fault_i <= f;
      wait_sig(fault_alarm_out, 1'b1, c, np);
      chk_reg(32'(np), 32'(exp_np(f, 1)));
    end
    conclude();
  end
endmodule
`default_nettype wire
